// >>> scsl_pkg.sv
package scsl_pkg;
  // string lengths
  localparam int TB0_LEN = 32;
  localparam int QCMP_LEN = 16;
  localparam int QMODE_LEN = 45;
  // timebase word 0 field positions
  localparam int TB0_FAST_EN_N_BIT = 0;
  localparam int TB0_SLOW_EN_N_BIT = 2;
  localparam int TB0_FAST_LO = 3;
  localparam int TB0_FAST_W = 4;
  localparam int TB0_SLOW_LO = 7;
  localparam int TB0_SLOW_W = 24;
  // comparator string field positions
  localparam int QC_LEVEL_LO = 0;
  localparam int QC_LEVEL_W = 10;
  localparam int QC_SIGN_BIT = 10;
  localparam int QC_SLOPE_BIT = 11;
  localparam int QC_EN_N_BIT = 12;
  // mode string field positions
  localparam int QM_CFG_LO = 0;
  localparam int QM_CFG_W = 24;
  localparam int QM_CLR_LO = 24;
  localparam int QM_CLR_W = 10;
  localparam int QM_SUB_BIT = 34;
  localparam int QM_DLY_BIT = 35;
  localparam int QM_INIT_BIT = 36;
  localparam int QM_EDGE_LO = 37;
  localparam int QM_SEL_W = 4;
  localparam int QM_LVL_LO = 41;

  typedef struct packed {
    logic fast_en_n;
    logic slow_en_n;
    logic [TB0_FAST_W-1:0] fast_load;
    logic [TB0_SLOW_W-1:0] slow_load;
  } scsl_tb0_s;

  typedef struct packed {
    logic [QC_LEVEL_W-1:0] level;
    logic level_sign;
    logic slope;
    logic trig_en_n;
  } scsl_qcmp_s;

  typedef struct packed {
    logic [QM_CFG_W-1:0] counter_config_bits;
    logic [QM_CLR_W-1:0] clear_ctl;
    logic submode;
    logic delayed_select;
    logic initial_state;
    logic [QM_SEL_W-1:0] edge_latch_selects;
    logic [QM_SEL_W-1:0] level_selects;
  } scsl_qmode_s;

  // serial input group for one string
  typedef struct packed {
    logic data;
    logic shift;
  } scsl_ser_s;
endpackage

// >>> scsl_loader.sv
// Summary of operation
// - word0: bit0 low enables 25 ns, bit2 low slower, bits3-6 fast load, bit1 ignored
// - word0: bits7-30 slow counter load, bit31 ignored, 32 bits, bit0 first
// - comparator: bits0-9 trigger level magnitude, bit10 level sign
// - comparator: bit11 slope, bit12 active-low enable, bits13-15 ignored
// - mode string: 45 bits, config, clear/control, submode, delay, init, edge, level
// - strings enter least-significant bit first
`timescale 1ns/10ps
module scsl_shift_rx #(
  parameter int LEN = 32
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_data,
  input wire logic i_shift,
  output logic [LEN-1:0] o_word,
  output logic o_done
);
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);
  logic [LEN-1:0] sh_r;
  logic [CW-1:0] cnt_r;

  // shift right so the first bit lands at bit 0 once full
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sh_r <= '0;
    end else if (i_ce && i_shift) begin
      sh_r <= {i_data, sh_r[LEN-1:1]};
    end
  end

  // bit counter; wraps after the last bit of each string
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else if (i_ce && i_shift) begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
    end
  end

  // latch all bits at once so consumers never see a half string
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_word <= '0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= i_shift && (cnt_r == LAST);
      if (i_shift && (cnt_r == LAST)) begin
        o_word <= {i_data, sh_r[LEN-1:1]};
      end
    end
  end

  // the last strobe must land its bit at the top of the word and raise done together
  property p_count;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_shift && cnt_r == LAST) |=> o_done && o_word[LEN-1] == $past(i_data);
  endproperty
  a_count: assert property (p_count) else $error("word not latched at last bit");

  // each new bit enters at the top, so the first bit sent ends up at bit 0
  property p_shift_in;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && i_shift) |=> sh_r[LEN-1] == $past(i_data);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shifted bit not at top of register");
endmodule

///////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module scsl_loader
  import scsl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire scsl_ser_s i_tb0_ser,
  input wire scsl_ser_s i_qcmp_ser,
  input wire scsl_ser_s i_qmode_ser,
  output scsl_tb0_s o_tb0,
  output scsl_qcmp_s o_qcmp,
  output scsl_qmode_s o_qmode,
  output logic o_tb0_done,
  output logic o_qcmp_done,
  output logic o_qmode_done
);
  // pins come from the processor board: two flops before use
  logic [5:0] meta_r;
  logic [5:0] sync_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (i_ce) begin
      meta_r <= {i_tb0_ser, i_qcmp_ser, i_qmode_ser};
      sync_r <= meta_r;
    end
  end

  // shift strobe is a level from the sender; one bit per rising edge
  logic [2:0] shift_d_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_d_r <= '0;
    end else if (i_ce) begin
      shift_d_r <= {sync_r[4], sync_r[2], sync_r[0]};
    end
  end
  logic [2:0] edge_w;
  assign edge_w = {sync_r[4], sync_r[2], sync_r[0]} & ~shift_d_r;

  logic [TB0_LEN-1:0] tb0_w;
  logic [QCMP_LEN-1:0] qc_w;
  logic [QMODE_LEN-1:0] qm_w;
  logic tb0_done_w;
  logic qc_done_w;
  logic qm_done_w;

  ///////////////////////////////////////////////////////////////////////////////
  scsl_shift_rx #(.LEN(TB0_LEN)) u_tb0 (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_data(sync_r[5]), .i_shift(edge_w[2]),
    .o_word(tb0_w), .o_done(tb0_done_w));
  scsl_shift_rx #(.LEN(QCMP_LEN)) u_qcmp (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_data(sync_r[3]), .i_shift(edge_w[1]),
    .o_word(qc_w), .o_done(qc_done_w));
  scsl_shift_rx #(.LEN(QMODE_LEN)) u_qmode (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_data(sync_r[1]), .i_shift(edge_w[0]),
    .o_word(qm_w), .o_done(qm_done_w));

  ///////////////////////////////////////////////////////////////////////////////
  // decode word 0; bits 1 and 31 are dropped; reset leaves both rates disabled
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_tb0 <= '{fast_en_n: 1'b1, slow_en_n: 1'b1, default: '0};
      o_tb0_done <= 1'b0;
    end else if (i_ce) begin
      o_tb0_done <= tb0_done_w;
      // only on done: the cleared receiver word would otherwise enable both rates
      if (tb0_done_w) begin
        o_tb0.fast_en_n <= tb0_w[TB0_FAST_EN_N_BIT];
        o_tb0.slow_en_n <= tb0_w[TB0_SLOW_EN_N_BIT];
        o_tb0.fast_load <= tb0_w[TB0_FAST_LO +: TB0_FAST_W];
        o_tb0.slow_load <= tb0_w[TB0_SLOW_LO +: TB0_SLOW_W];
      end
    end
  end

  // decode comparator string; trigger disabled out of reset, bits 13-15 dropped
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_qcmp <= '{trig_en_n: 1'b1, default: '0};
      o_qcmp_done <= 1'b0;
    end else if (i_ce) begin
      o_qcmp_done <= qc_done_w;
      if (qc_done_w) begin
        o_qcmp.level <= qc_w[QC_LEVEL_LO +: QC_LEVEL_W];
        o_qcmp.level_sign <= qc_w[QC_SIGN_BIT];
        o_qcmp.slope <= qc_w[QC_SLOPE_BIT];
        o_qcmp.trig_en_n <= qc_w[QC_EN_N_BIT];
      end
    end
  end

  // decode mode string fields
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_qmode <= '0;
      o_qmode_done <= 1'b0;
    end else if (i_ce) begin
      o_qmode_done <= qm_done_w;
      if (qm_done_w) begin
        o_qmode.counter_config_bits <= qm_w[QM_CFG_LO +: QM_CFG_W];
        o_qmode.clear_ctl <= qm_w[QM_CLR_LO +: QM_CLR_W];
        o_qmode.submode <= qm_w[QM_SUB_BIT];
        o_qmode.delayed_select <= qm_w[QM_DLY_BIT];
        o_qmode.initial_state <= qm_w[QM_INIT_BIT];
        o_qmode.edge_latch_selects <= qm_w[QM_EDGE_LO +: QM_SEL_W];
        o_qmode.level_selects <= qm_w[QM_LVL_LO +: QM_SEL_W];
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////////////
  // decoded fields must match the latched word one cycle after its done
  property p_tb0_fast;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && tb0_done_w) |=> o_tb0.fast_load == $past(tb0_w[TB0_FAST_LO +: TB0_FAST_W])
      && o_tb0.fast_en_n == $past(tb0_w[TB0_FAST_EN_N_BIT]);
  endproperty
  a_tb0_fast: assert property (p_tb0_fast) else $error("fast rate fields wrong");

  property p_tb0_slow;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && tb0_done_w) |=> o_tb0.slow_load == $past(tb0_w[TB0_SLOW_LO +: TB0_SLOW_W])
      && o_tb0.slow_en_n == $past(tb0_w[TB0_SLOW_EN_N_BIT]);
  endproperty
  a_tb0_slow: assert property (p_tb0_slow) else $error("slow rate fields wrong");

  property p_qc_level;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && qc_done_w) |=> o_qcmp.level == $past(qc_w[QC_LEVEL_LO +: QC_LEVEL_W])
      && o_qcmp.level_sign == $past(qc_w[QC_SIGN_BIT]);
  endproperty
  a_qc_level: assert property (p_qc_level) else $error("trigger level wrong");

  property p_qc_ctl;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && qc_done_w) |=> o_qcmp.slope == $past(qc_w[QC_SLOPE_BIT]) && o_qcmp.trig_en_n == $past(qc_w[QC_EN_N_BIT]);
  endproperty
  a_qc_ctl: assert property (p_qc_ctl) else $error("slope or enable wrong");

  property p_qm_fields;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && qm_done_w) |=> o_qmode.level_selects == $past(qm_w[QM_LVL_LO +: QM_SEL_W])
      && o_qmode.edge_latch_selects == $past(qm_w[QM_EDGE_LO +: QM_SEL_W])
      && o_qmode.initial_state == $past(qm_w[QM_INIT_BIT]);
  endproperty
  a_qm_fields: assert property (p_qm_fields) else $error("mode fields wrong");

  // outputs may only move on the cycle after a done; a half string never leaks out
  property p_hold;
    @(posedge i_mclk) disable iff (i_rst)
    (i_ce && !$past(qm_done_w) && !qm_done_w) |=> $stable(o_qmode);
  endproperty
  a_hold: assert property (p_hold) else $error("mode outputs moved mid string");

  property p_hold_qc;
    @(posedge i_mclk) disable iff (i_rst)
    (!qc_done_w && !$past(qc_done_w)) |=> $stable(o_qcmp);
  endproperty
  a_hold_qc: assert property (p_hold_qc) else $error("comparator outputs moved mid string");

  // also guards the reset values of the rate enables until the first word
  property p_hold_tb0;
    @(posedge i_mclk) disable iff (i_rst)
    !tb0_done_w |=> $stable(o_tb0);
  endproperty
  a_hold_tb0: assert property (p_hold_tb0) else $error("word 0 outputs moved mid string");
endmodule

// >>> scsl_sender.sv
`timescale 1ns/10ps
module scsl_sender
  import scsl_pkg::*;
#(
  parameter int LEN = 16
) (
  input wire logic i_mclk,
  input wire logic i_go,
  input wire logic [3:0] i_gap,
  input wire logic [LEN-1:0] i_word,
  output scsl_ser_s o_ser,
  output logic o_busy
);
  int idx;
  int ph;
  // word and gap latched at start so the bench may set up the next string early
  logic [3:0] gap_r;
  logic [LEN-1:0] word_r;
  initial begin
    o_ser = '0;
    o_busy = 1'b0;
  end
  // one bit a slot, lsb first; strobe high 3 cycles, low 3+gap so slow senders get tried
  always @(posedge i_mclk) begin
    if (!o_busy) begin
      o_busy <= i_go;
      idx <= 0;
      ph <= 0;
      gap_r <= i_gap;
      word_r <= i_word;
    end else begin
      ph <= (ph == 5 + gap_r) ? 0 : ph + 1;
      if (ph == 0) o_ser.data <= word_r[idx];
      if (ph == 1) o_ser.shift <= 1'b1;
      if (ph == 4) o_ser.shift <= 1'b0;
      if (ph == 5 + gap_r) begin
        idx <= idx + 1;
        // released line shows the inverse, never a stale copy
        if (idx == LEN - 1) o_busy <= 1'b0;
        if (idx == LEN - 1) o_ser.data <= ~o_ser.data;
      end
    end
  end
endmodule

// >>> serial_control_string_loader_test.sv
`timescale 1ns/10ps
module serial_control_string_loader_test;
  import scsl_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] go = '0;
  logic [3:0] gap = '0;
  logic ce = 1'b1;
  logic ce_prev = 1'b1;
  logic [63:0] w = '0;
  wire [2:0] busy;
  wire [2:0] dn;
  scsl_ser_s ser0, ser1, ser2;
  scsl_tb0_s o_tb0;
  scsl_qcmp_s o_qcmp;
  scsl_qmode_s o_qmode;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [63:0] eold [3];
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  scsl_sender #(.LEN(TB0_LEN)) u_s0 (.i_mclk(i_mclk), .i_go(go[0]), .i_gap(gap), .i_word(w[31:0]),
    .o_ser(ser0), .o_busy(busy[0]));
  scsl_sender #(.LEN(QCMP_LEN)) u_s1 (.i_mclk(i_mclk), .i_go(go[1]), .i_gap(gap), .i_word(w[15:0]),
    .o_ser(ser1), .o_busy(busy[1]));
  scsl_sender #(.LEN(QMODE_LEN)) u_s2 (.i_mclk(i_mclk), .i_go(go[2]), .i_gap(gap), .i_word(w[44:0]),
    .o_ser(ser2), .o_busy(busy[2]));
  // enable drops for single cycles only, so each strobe level still gets two samples
  always @(posedge i_mclk) begin
    ce_prev <= ce;
    ce <= (ce && ce_prev) ? ($urandom_range(0, 7) != 0) : 1'b1;
  end
  scsl_loader u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_tb0_ser(ser0), .i_qcmp_ser(ser1),
    .i_qmode_ser(ser2), .o_tb0(o_tb0), .o_qcmp(o_qcmp), .o_qmode(o_qmode), .o_tb0_done(dn[0]),
    .o_qcmp_done(dn[1]), .o_qmode_done(dn[2]));
  ////////////////////////////////////////////////////////////////////////////
  // bench model: decoded fields in struct order, from the word alone
  function automatic logic [63:0] model(input int s, input logic [63:0] v);
    if (s == 0) return 64'({v[0], v[2], v[6:3], v[30:7]});
    if (s == 1) return 64'({v[9:0], v[10], v[11], v[12]});
    return 64'({v[23:0], v[33:24], v[34], v[35], v[36], v[40:37], v[44:41]});
  endfunction
  function automatic logic [63:0] got(input int s);
    return (s == 0) ? 64'(o_tb0) : (s == 1) ? 64'(o_qcmp) : 64'(o_qmode);
  endfunction
  task automatic chk(input logic [63:0] a, input logic [63:0] b, input string m);
    checks_done++;
    if (a !== b) begin
      fail_count++;
      $display("mismatch %0t %s got %h exp %h", $time, m, a, b);
    end
  endtask
  task automatic close_out();
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // send one string; outputs must hold old values until the done pulse
  task automatic xfer(input int s);
    int n;
    while (busy[s] === 1'b1) @(posedge i_mclk);
    @(posedge i_mclk);
    w <= {$urandom, $urandom};
    gap <= 4'($urandom_range(0, 9));
    go[s] <= 1'b1;
    @(posedge i_mclk);
    go[s] <= 1'b0;
    n = 0;
    forever begin
      @(posedge i_mclk);
      #1;
      n++;
      if (dn[s] === 1'b1 || n > 2000) break;
      chk(got(s), eold[s], "output moved mid-string");
    end
    eold[s] = model(s, w);
    chk(64'(dn[s]), 64'h1, "no done pulse");
    chk(got(s), eold[s], "decoded fields");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, well above 60 strings of at most 45 slow bits
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h4C3F));
    eold[0] = 64'h3000_0000;
    eold[1] = 64'h1;
    eold[2] = 64'h0;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    #1;
    for (int s = 0; s < 3; s++) chk(got(s), eold[s], "reset value");
    // all strings loaded back to back, as before an acquisition start
    for (int k = 0; k < 20; k++) begin
      for (int s = 0; s < 3; s++) xfer(s);
    end
    close_out();
  end
endmodule
